// ===== core/async_serial_unit.sv
// full-duplex asynchronous serial transmitter and receiver
`include "serial_unit_map.svh"
`timescale 1ns/1ps
module async_serial_unit import serial_unit_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire serial_control_t ctrl_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_ninth_bit_i,
  input wire logic tx_write_i,
  output logic tx_write_ready_o,
  input wire logic status_read_i,
  input wire logic data_read_i,
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  output logic serial_tx_oe_o,
  output logic [7:0] rx_data_o,
  output logic rx_ninth_bit_o,
  output serial_status_t status_o
);
  typedef struct packed {
    logic [1:0] rx_sync;
    tx_state_t tx_st;
    logic [15:0] tx_div;
    logic [3:0] tx_tick;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic tx_par;
    logic tx_first;
    logic tx_was_en;
    logic tx_pin;
    logic tx_oe;
    rx_state_t rx_st;
    logic [15:0] rx_div;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic [2:0] samp;
    logic rx_noise;
    logic rx_par;
    logic [4:0] idle_cnt;
    logic idle_armed;
    logic rx_prev;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic status_seen;
    serial_status_t stat;
  } core_state_t;

  core_state_t st_ff, nxt_st;
  logic buf_ready, buf_valid, buf_pop;
  tx_word_t buf_word, in_word;
  logic tx_stick, rx_stick, rx_in, vote, agree;
  logic [15:0] tx_period, rx_period;
  logic [8:0] rx_word;
  logic [3:0] nbits;

  // pick conventional or fine divider; result in system clocks per tick
  function automatic logic [15:0] period(input logic fine,
      input logic [7:0] fine_v, input logic [1:0] pre,
      input logic [2:0] pow);
    logic [15:0] p;
    p = 16'h0001;
    unique case (pre)
      `PR_1: p = 16'h0001;
      `PR_3: p = 16'h0003;
      `PR_4: p = 16'h0004;
      `PR_13: p = 16'h000d;
    endcase
    p = p << pow;
    if (fine && fine_v != 8'h00) begin
      p = {8'h00, fine_v};
    end
    // floor keeps the rate at or below the 500K baud ceiling
    if (p < `MIN_DIV) begin
      p = 16'(`MIN_DIV);
    end
    return p;
  endfunction

  assign in_word = '{data: tx_data_i, ninth: tx_ninth_bit_i};

  word_buffer #(.WIDTH(9)) tx_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_data_i(in_word),
    .in_valid_i(tx_write_i),
    .in_ready_o(buf_ready),
    .out_data_o(buf_word),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop)
  );

  always_comb begin
    tx_period = period(ctrl_i.fine_mode, ctrl_i.tx_fine, ctrl_i.tx_pre,
                       ctrl_i.tx_pow);
    rx_period = period(ctrl_i.fine_mode, ctrl_i.rx_fine, ctrl_i.rx_pre,
                       ctrl_i.rx_pow);
    tx_stick = (st_ff.tx_div >= tx_period - 16'h0001);
    rx_stick = (st_ff.rx_div >= rx_period - 16'h0001);
    nbits = ctrl_i.word9 ? 4'd9 : 4'd8;
    rx_in = st_ff.rx_sync[1];
    vote = (st_ff.samp[0] & st_ff.samp[1]) | (st_ff.samp[0] & rx_in) |
           (st_ff.samp[1] & rx_in);
    agree = (st_ff.samp[0] == st_ff.samp[1]) && (st_ff.samp[1] == rx_in);
    rx_word = st_ff.rx_shift;
    buf_pop = 1'b0;
    nxt_st = st_ff;
    nxt_st.rx_sync = {st_ff.rx_sync[0], serial_rx_pin_i};
    nxt_st.tx_div = tx_stick ? 16'h0000 : st_ff.tx_div + 16'h0001;
    nxt_st.rx_div = rx_stick ? 16'h0000 : st_ff.rx_div + 16'h0001;
    nxt_st.tx_was_en = ctrl_i.tx_en;

    // clear sequence: status access then data access
    if (status_read_i) begin
      nxt_st.status_seen = 1'b1;
    end
    if (st_ff.status_seen && tx_write_i) begin
      nxt_st.stat.tx_complete = 1'b0;
      nxt_st.status_seen = 1'b0;
    end
    if (st_ff.status_seen && data_read_i) begin
      nxt_st.stat.rx_full = 1'b0;
      nxt_st.stat.overrun = 1'b0;
      nxt_st.stat.noise_flag = 1'b0;
      nxt_st.stat.framing = 1'b0;
      nxt_st.stat.parity_err = 1'b0;
      nxt_st.stat.idle_seen = 1'b0;
      nxt_st.status_seen = 1'b0;
    end

    // transmitter
    if (!ctrl_i.tx_en) begin
      nxt_st.tx_st = TX_OFF;
    end else if (st_ff.tx_st == TX_OFF || !st_ff.tx_was_en) begin
      nxt_st.tx_st = TX_IDLE;
      nxt_st.tx_first = 1'b1; // send an idle frame first
      nxt_st.tx_tick = 4'h0;
      nxt_st.tx_bit = 4'h0;
    end else if (tx_stick) begin
      nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
      if (st_ff.tx_tick == `SAMPLE_LAST) begin
        unique case (st_ff.tx_st)
          TX_OFF: nxt_st.tx_st = TX_IDLE;
          TX_IDLE: begin
            if (st_ff.tx_first) begin
              nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
              if (st_ff.tx_bit == nbits + 4'd1) begin
                nxt_st.tx_first = 1'b0;
                nxt_st.tx_bit = 4'h0;
              end
            end else if (ctrl_i.send_break) begin
              nxt_st.tx_shift = 9'h000;
              nxt_st.tx_par = 1'b0;
              nxt_st.tx_st = TX_START;
            end else if (buf_valid) begin
              buf_pop = 1'b1;
              nxt_st.tx_shift = {ctrl_i.word9 & buf_word.ninth,
                                 buf_word.data};
              nxt_st.tx_par = ^{ctrl_i.word9 & buf_word.ninth,
                                buf_word.data} ^ ctrl_i.parity_odd;
              nxt_st.tx_st = TX_START;
            end
          end
          TX_START: begin
            nxt_st.tx_st = TX_DATA;
            nxt_st.tx_bit = 4'h0;
          end
          TX_DATA: begin
            nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
            nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
            if (st_ff.tx_bit == nbits - 4'd1) begin
              nxt_st.tx_st = ctrl_i.parity_en ? TX_PARITY : TX_STOP;
            end
          end
          TX_PARITY: nxt_st.tx_st = TX_STOP;
          TX_STOP: begin
            if (ctrl_i.send_break) begin
              nxt_st.tx_st = TX_START;
            end else if (st_ff.tx_shift == 9'h000 && !st_ff.tx_par &&
                         st_ff.tx_pin == 1'b0) begin
              nxt_st.tx_st = TX_MARK;
            end else begin
              nxt_st.tx_st = TX_IDLE;
              nxt_st.stat.tx_complete = 1'b1;
            end
          end
          TX_MARK: nxt_st.tx_st = TX_IDLE;
        endcase
      end
    end
    unique case (nxt_st.tx_st)
      TX_START: nxt_st.tx_pin = 1'b0;
      TX_DATA: nxt_st.tx_pin = nxt_st.tx_shift[0];
      TX_PARITY: nxt_st.tx_pin = nxt_st.tx_par;
      TX_STOP: nxt_st.tx_pin = !ctrl_i.send_break;
      default: nxt_st.tx_pin = `TX_IDLE_LEVEL;
    endcase
    nxt_st.tx_oe = ctrl_i.tx_en | ctrl_i.rx_en;
    nxt_st.stat.tx_empty = buf_ready && !(buf_valid && !buf_pop) ||
                           (buf_pop && !tx_write_i);

    // receiver
    nxt_st.stat.muted = st_ff.stat.muted | ctrl_i.mute_req;
    if (!ctrl_i.mute_req && !st_ff.stat.muted) begin
      nxt_st.stat.muted = 1'b0;
    end
    nxt_st.rx_prev = rx_in;
    if (!ctrl_i.rx_en) begin
      nxt_st.rx_st = RX_HUNT;
      nxt_st.idle_cnt = 5'h00;
    end else if (st_ff.rx_st == RX_HUNT) begin
      if (st_ff.rx_prev && !rx_in) begin
        nxt_st.rx_st = RX_START;
        nxt_st.rx_tick = 4'h0;
        nxt_st.rx_noise = 1'b0;
        nxt_st.rx_div = 16'h0000;
      end else if (rx_stick && rx_in) begin
        nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
        if (st_ff.rx_tick == `SAMPLE_LAST &&
            st_ff.idle_cnt != 5'h1f) begin
          nxt_st.idle_cnt = st_ff.idle_cnt + 5'h01;
        end
        if (st_ff.idle_armed &&
            st_ff.idle_cnt == {1'b0, nbits} + 5'd2) begin
          nxt_st.idle_armed = 1'b0;
          if (st_ff.stat.muted && !ctrl_i.wake_addr) begin
            nxt_st.stat.muted = 1'b0;
          end else if (!st_ff.stat.muted) begin
            nxt_st.stat.idle_seen = 1'b1;
          end
        end
      end
    end else if (rx_stick) begin
      nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
      if (st_ff.rx_tick == `SAMPLE_MID_A) begin
        nxt_st.samp[0] = rx_in;
      end
      if (st_ff.rx_tick == `SAMPLE_MID_B) begin
        nxt_st.samp[1] = rx_in;
      end
      if (st_ff.rx_tick == `SAMPLE_MID_C) begin
        if (!agree) begin
          nxt_st.rx_noise = 1'b1;
        end
        unique case (st_ff.rx_st)
          RX_HUNT: nxt_st.rx_st = RX_HUNT;
          RX_START: begin
            nxt_st.rx_st = vote ? RX_HUNT : RX_BITS;
            nxt_st.rx_bit = 4'h0;
            nxt_st.rx_par = 1'b0;
          end
          RX_BITS: begin
            nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
            if (st_ff.rx_bit < nbits) begin
              nxt_st.rx_shift = {1'b0, st_ff.rx_shift[8:1]};
              nxt_st.rx_shift[nbits - 4'd1] = vote;
            end
            nxt_st.rx_par = st_ff.rx_par ^ vote;
            if (st_ff.rx_bit == nbits - 4'd1 +
                {3'b000, ctrl_i.parity_en}) begin
              nxt_st.rx_st = RX_STOP;
            end
          end
          RX_STOP: begin
            nxt_st.rx_st = RX_HUNT;
            nxt_st.idle_cnt = 5'h00;
            nxt_st.idle_armed = 1'b1;
            nxt_st.rx_tick = 4'h0;
            if (st_ff.stat.muted && ctrl_i.wake_addr &&
                rx_word[nbits - 4'd1]) begin
              nxt_st.stat.muted = 1'b0;
            end
            if (!st_ff.stat.muted || (ctrl_i.wake_addr &&
                rx_word[nbits - 4'd1])) begin
              if (st_ff.stat.rx_full && !nxt_st.status_seen) begin
                nxt_st.stat.overrun = 1'b1;
              end else begin
                nxt_st.rx_data = rx_word[7:0];
                nxt_st.rx_ninth = rx_word[8];
                nxt_st.stat.rx_full = 1'b1;
                nxt_st.stat.noise_flag = st_ff.rx_noise | !agree;
                nxt_st.stat.framing = !vote;
                nxt_st.stat.parity_err = ctrl_i.parity_en &&
                  (st_ff.rx_par != ctrl_i.parity_odd);
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.rx_sync <= 2'b11;
      st_ff.rx_prev <= 1'b1;
      st_ff.tx_pin <= 1'b1;
      st_ff.stat.tx_empty <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tx_write_ready_o = buf_ready;
  assign serial_tx_pin_o = st_ff.tx_pin;
  assign serial_tx_oe_o = st_ff.tx_oe;
  assign rx_data_o = st_ff.rx_data;
  assign rx_ninth_bit_o = st_ff.rx_ninth;
  assign status_o = st_ff.stat;
endmodule

// ===== core/serial_unit_map.svh
// constants: control encodings, idle line level and timing counts
`ifndef SERIAL_UNIT_MAP_SVH
`define SERIAL_UNIT_MAP_SVH
`define SAMPLES_PER_BIT 5'h10
`define SAMPLE_MID_A 4'h7
`define SAMPLE_MID_B 4'h8
`define SAMPLE_MID_C 4'h9
`define SAMPLE_LAST 4'hf
`define TX_IDLE_LEVEL 1'b1
`define MAX_BAUD 32'd500000
`define CLK_HZ 32'd200000000
`define MIN_DIV (`CLK_HZ / (`MAX_BAUD * 32'd16))
`define PR_1 2'b00
`define PR_3 2'b01
`define PR_4 2'b10
`define PR_13 2'b11
`endif

// ===== core/serial_unit_pkg.sv
// types shared by the serial unit core and its buffer
package serial_unit_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } tx_word_t;

  typedef struct packed {
    logic word9;
    logic parity_en;
    logic parity_odd;
    logic tx_en;
    logic rx_en;
    logic send_break;
    logic mute_req;
    logic wake_addr;
    logic fine_mode;
    logic [1:0] tx_pre;
    logic [2:0] tx_pow;
    logic [1:0] rx_pre;
    logic [2:0] rx_pow;
    logic [7:0] tx_fine;
    logic [7:0] rx_fine;
  } serial_control_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_complete;
    logic rx_full;
    logic idle_seen;
    logic overrun;
    logic noise_flag;
    logic framing;
    logic parity_err;
    logic muted;
  } serial_status_t;

  typedef enum logic [2:0] {
    TX_OFF, TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_MARK
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT, RX_START, RX_BITS, RX_STOP
  } rx_state_t;
endpackage

// ===== core/word_buffer.sv
// two-entry valid/ready buffer for transmit words
`timescale 1ns/1ps
module word_buffer import serial_unit_pkg::*; #(
  parameter int WIDTH = 9
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] count;
  } buf_state_t;
  buf_state_t st_ff, nxt_st;
  logic push, pop;

  always_comb begin
    nxt_st = st_ff;
    push = in_valid_i && (st_ff.count != 2'd2);
    pop = out_ready_i && (st_ff.count != 2'd0);
    if (pop) begin
      nxt_st.mem[0] = st_ff.mem[1];
    end
    if (push) begin
      if (pop) begin
        nxt_st.mem[st_ff.count - 2'd1] = in_data_i;
      end else begin
        nxt_st.mem[st_ff.count[0]] = in_data_i;
      end
    end
    nxt_st.count = st_ff.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready_o = (st_ff.count != 2'd2);
  assign out_valid_o = (st_ff.count != 2'd0);
  assign out_data_o = st_ff.mem[0];
endmodule

// ===== tb/async_serial_unit_assertions.sv
// port-level properties of the serial unit
`timescale 1ns/1ps
module async_serial_unit_assertions import serial_unit_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire serial_control_t ctrl_i,
  input wire logic data_read_i,
  input wire logic serial_tx_pin_o,
  input wire logic serial_tx_oe_o,
  input wire logic [7:0] rx_data_o,
  input wire serial_status_t status_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence start_edge;
    serial_tx_oe_o && $past(serial_tx_pin_o) && !serial_tx_pin_o;
  endsequence
  sequence line_low;
    !serial_tx_pin_o [*8];
  endsequence
  sequence line_high;
    serial_tx_pin_o [*8];
  endsequence
  AST_START_LOW: assert property (start_edge |-> line_low)
    else $error("start bit too short");
  AST_STOP_HIGH: assert property (
    $rose(status_o.tx_complete) |-> $past(serial_tx_pin_o))
    else $error("frame completed without a high stop bit");
  AST_OE_OFF: assert property (
    !(ctrl_i.tx_en || ctrl_i.rx_en) |=> !serial_tx_oe_o)
    else $error("pin still driven with both directions off");
  AST_IDLE_HIGH: assert property ($rose(serial_tx_oe_o) |-> line_high)
    else $error("pin not high after enable");
  AST_RX_FULL_HOLD: assert property (
    status_o.rx_full && ctrl_i.rx_en && !data_read_i |=> status_o.rx_full)
    else $error("rx full dropped without a data read");
  AST_DATA_KEPT: assert property (
    status_o.rx_full && $past(status_o.rx_full) |-> $stable(rx_data_o))
    else $error("received word changed while unread");
  AST_OVR_WHEN_FULL: assert property (
    $rose(status_o.overrun) |-> $past(status_o.rx_full))
    else $error("overrun without a full buffer");
  AST_FE_WITH_FULL: assert property (
    $rose(status_o.framing) |-> status_o.rx_full)
    else $error("framing flag without a received word");
  AST_RESET_STATE: assert property (
    $fell(rst_i) |-> status_o.tx_empty && !status_o.rx_full
      && !serial_tx_oe_o)
    else $error("wrong state after reset");
endmodule

// ===== tb/async_serial_unit_tb_top.sv
// self-checking bench for the serial unit against a far-side peer
`timescale 1ns/1ps
module async_serial_unit_tb_top import serial_unit_pkg::*;;
  logic clk, rst, wr, rdy, sread, dread, rx_pin, tx_pin, tx_oe, rninth;
  logic got_v, wninth, rx_prev;
  logic [7:0] wdata, rdata;
  logic [3:0] nbits;
  logic [10:0] got;
  logic [15:0] seed;
  logic [10:0] tx_q[$];
  logic [10:0] rx_q[$];
  serial_control_t ctrl;
  serial_status_t status;
  int fail_count, samples_checked;
  async_serial_unit DUT (.sys_clk_i(clk), .rst_i(rst), .ctrl_i(ctrl),
    .tx_data_i(wdata), .tx_ninth_bit_i(wninth), .tx_write_i(wr),
    .tx_write_ready_o(rdy), .status_read_i(sread), .data_read_i(dread),
    .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin),
    .serial_tx_oe_o(tx_oe), .rx_data_o(rdata), .rx_ninth_bit_o(rninth),
    .status_o(status));
  // 16 ticks of 25 clocks: the smallest divider clamps to this
  serial_peer #(.BIT_CLKS(400)) peer (.sys_clk_i(clk), .tx_pin_i(tx_pin),
    .tx_oe_i(tx_oe), .nbits_i(nbits), .rx_pin_o(rx_pin), .got_o(got),
    .got_valid_o(got_v));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [10:0] frame(input logic [8:0] w);
    logic [10:0] e;
    int n;
    n = 8 + ctrl.word9;
    e = ctrl.word9 ? {2'b00, w} : {3'b000, w[7:0]};
    if (ctrl.parity_en) begin
      e[n] = ^e ^ ctrl.parity_odd;
      n++;
    end
    e[n] = 1'b1;
    return e;
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_flag(input int which, input int lim);
    int n;
    n = 0;
    while (n < lim && !(which == 0 ? tx_q.size() == 0 :
        which == 1 ? status.rx_full === 1'b1 : rdy === 1'b1)) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic write_word(input logic [8:0] w);
    wait_flag(2, 20000);
    wdata = w[7:0];
    wninth = w[8];
    wr = 1'b1;
    tx_q.push_back(frame(w));
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic clear_rx();
    sread = 1'b1;
    @(negedge clk);
    sread = 1'b0;
    dread = 1'b1;
    @(negedge clk);
    dread = 1'b0;
    @(negedge clk);
  endtask
  task automatic rx_frame(input logic [8:0] w, input logic stop);
    rx_q.push_back({1'b0, ~stop, w[8] & ctrl.word9, w[7:0]});
    peer.send(w, 8 + ctrl.word9, stop);
    wait_flag(1, 2000);
  endtask
  // results are matched against the oldest note as they appear
  always @(negedge clk) begin
    rx_prev <= status.rx_full;
    if (got_v === 1'b1) begin
      check(got, tx_q.size() ? tx_q.pop_front() : ~got);
    end
    if (status.rx_full === 1'b1 && rx_prev !== 1'b1) begin
      check({status.noise_flag | status.parity_err, status.framing,
        rninth & ctrl.word9, rdata},
        rx_q.size() ? rx_q.pop_front() : 11'h7ff);
    end
  end
  initial begin
    int n;
    {rst, wr, sread, dread, wninth} = 5'h10;
    wdata = 8'h00;
    ctrl = '0;
    nbits = 4'h8;
    seed = 16'h3a9d;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({7'h00, tx_oe, tx_pin, status.tx_empty, status.rx_full},
      11'h006);
    for (int m = 0; m < 3; m++) begin
      ctrl.tx_en = 1'b0;
      @(negedge clk);
      ctrl.word9 = m[0];
      ctrl.parity_en = (m != 0);
      ctrl.parity_odd = m[1];
      nbits = 4'(8 + m[0] + (m != 0));
      ctrl.tx_en = 1'b1;
      n = 0;
      repeat (4000) begin
        @(negedge clk);
        n += (tx_pin !== 1'b1);
      end
      check({10'h000, tx_oe} | 11'(n << 1), 11'h001);
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        write_word(seed[8:0]);
      end
      check({10'h000, rdy}, 11'h000);
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      wait_flag(0, 20000);
      repeat (400) @(negedge clk);
      check({9'h000, status.tx_empty, status.tx_complete}, 11'h003);
    end
    ctrl.tx_en = 1'b0;
    ctrl.word9 = 1'b0;
    ctrl.parity_en = 1'b0;
    ctrl.rx_en = 1'b1;
    repeat (800) @(negedge clk);
    seed = lfsr(seed);
    rx_frame(seed[8:0], 1'b1);
    peer.send(~seed[8:0], 8, 1'b1);
    check({2'b00, status.overrun, rdata}, {3'b001, seed[7:0]});
    clear_rx();
    check({9'h000, status.rx_full, status.overrun}, 11'h000);
    rx_frame(~seed[8:0], 1'b0);
    clear_rx();
    ctrl.rx_en = 1'b0;
    @(negedge clk);
    ctrl.word9 = 1'b1;
    ctrl.rx_en = 1'b1;
    repeat (800) @(negedge clk);
    rx_frame({1'b1, seed[15:8]}, 1'b1);
    repeat (4400) @(negedge clk);
    check({10'h000, status.idle_seen}, 11'h001);
    clear_rx();
    ctrl.rx_en = 1'b0;
    repeat (2) @(negedge clk);
    check({10'h000, tx_oe}, 11'h000);
    stop_test();
  end
endmodule
bind async_serial_unit async_serial_unit_assertions chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ctrl_i(ctrl_i),
  .data_read_i(data_read_i), .serial_tx_pin_o(serial_tx_pin_o),
  .serial_tx_oe_o(serial_tx_oe_o), .rx_data_o(rx_data_o),
  .status_o(status_o));

// ===== tb/serial_peer.sv
// far-side equipment: decodes the transmit pin, sends on the receive pin
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_CLKS = 400
) (
  input wire logic sys_clk_i,
  input wire logic tx_pin_i,
  input wire logic tx_oe_i,
  input wire logic [3:0] nbits_i,
  output logic rx_pin_o,
  output logic [10:0] got_o,
  output logic got_valid_o
);
  logic [10:0] w;
  initial begin
    rx_pin_o = 1'b1;
    got_o = '0;
    got_valid_o = 1'b0;
  end
  // mid-bit sampling; the stop bit lands just above the last data or parity bit
  always begin
    @(negedge tx_pin_i);
    w = '0;
    repeat (BIT_CLKS / 2) @(posedge sys_clk_i);
    if (tx_oe_i && !tx_pin_i) begin
      for (int i = 0; i <= nbits_i; i++) begin
        repeat (BIT_CLKS) @(posedge sys_clk_i);
        w[i] = tx_pin_i;
      end
      got_o <= w;
      got_valid_o <= 1'b1;
      @(posedge sys_clk_i);
      got_valid_o <= 1'b0;
    end
  end
  task automatic send(input logic [8:0] word, input int nbits,
      input logic stop);
    rx_pin_o = 1'b0;
    repeat (BIT_CLKS) @(negedge sys_clk_i);
    for (int i = 0; i < nbits; i++) begin
      rx_pin_o = word[i];
      repeat (BIT_CLKS) @(negedge sys_clk_i);
    end
    rx_pin_o = stop;
    repeat (BIT_CLKS) @(negedge sys_clk_i);
    // pulled-up line returns high; one bit gap keeps idle detect quiet
    rx_pin_o = 1'b1;
    repeat (BIT_CLKS) @(negedge sys_clk_i);
  endtask
endmodule
